// ===== tb/gpio_host_model.sv
// host-side model of the header pins with on-board pull-ups
`timescale 1ns/1ns
module gpio_host_model
#(
    parameter int unsigned WIDTH = 8
)
(
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe,
    input  wire logic [WIDTH-1:0] host_val,
    input  wire logic [WIDTH-1:0] host_en,
    output logic      [WIDTH-1:0] pin_level
);
    // a line nobody drives floats up to one, never holds a stale value
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & (host_val | ~host_en));
endmodule

// ===== tb/gpio_two_bank_config_test.sv
// self-checking bench for the two-bank gpio block
`timescale 1ns/1ns
module gpio_two_bank_config_test;
    import gpio_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, net_activity, activity_led_line_n;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat, wdat;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [7:0]  serial_out, serial_oe, first_pin_in, first_pin_out, first_pin_oe;
    logic [7:0]  second_pin_in, second_pin_out, second_pin_oe, h1_val, h1_en, h2_val, h2_en;
    logic [7:0]  dir, dat, sdir;
    integer      seed;
    int          error_cnt, tests_run;

    gpio_two_bank_config dut (.*);
    gpio_host_model host1 (.pin_out(first_pin_out), .pin_oe(first_pin_oe), .host_val(h1_val),
                           .host_en(h1_en), .pin_level(first_pin_in));
    gpio_host_model host2 (.pin_out(second_pin_out), .pin_oe(second_pin_oe), .host_val(h2_val),
                           .host_en(h2_en), .pin_level(second_pin_in));

    // free-running 50 MHz clock
    always #10 aclk = ~aclk;

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                error_cnt++;
                $display("mismatch %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // expected line level: device drive wins, else host, else pull-up
    function automatic logic [7:0] lvl(input logic [7:0] oe, out, hv, he);
        return (oe & out) | (~oe & (hv | ~he));
    endfunction

    // one write: address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        begin
            s_axi_awaddr  <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata   <= d;
            s_axi_wvalid  <= 1'b1;
            b_t = 1'b0;
            // no cycle limit of its own: only the watchdog ends a wait that never finishes
            while (!b_t)
            begin
                @(negedge aclk);
                aw_t = s_axi_awvalid && s_axi_awready;
                w_t  = s_axi_wvalid && s_axi_wready;
                b_t  = s_axi_bvalid;
                resp = s_axi_bresp;
                @(posedge aclk);
                if (aw_t)
                    s_axi_awvalid <= 1'b0;
                if (w_t)
                    s_axi_wvalid <= 1'b0;
            end
        end
    endtask

    // one read; ready lines sit high, so the answer is taken on its first edge
    task automatic rd(input logic [3:0] a);
        logic g, t;
        begin
            s_axi_araddr  <= a;
            s_axi_arvalid <= 1'b1;
            t = 1'b0;
            while (!t)
            begin
                @(negedge aclk);
                g    = s_axi_arvalid && s_axi_arready;
                t    = s_axi_rvalid;
                rdat = s_axi_rdata;
                resp = s_axi_rresp;
                @(posedge aclk);
                if (g)
                    s_axi_arvalid <= 1'b0;
            end
        end
    endtask

    // verdict and end of run
    task automatic stop_test();
        begin
            $display("checks %0d, mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    // cuts a hang short, well past the expected run of some three hundred and forty cycles
    initial
    begin
        #400000;
        error_cnt++;
        stop_test();
    end

    // main sequence
    initial
    begin
        seed = 54;
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, net_activity} = 4'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        serial_out = 8'($random(seed));
        serial_oe = 8'($random(seed));
        {h1_val, h1_en, h2_val} = 24'($random(seed));
        h2_en = 8'($random(seed));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_BANK_FIRST);
        chk("first reset", rdat, {FIRST_FUNC_RST, FIRST_DIR_RST, 8'h00,
            lvl(serial_oe & FIRST_FUNC_RST, serial_out, h1_val, h1_en)});
        rd(OFS_BANK_SECOND);
        chk("second reset", rdat, {SECOND_FUNC_RST, SECOND_DIR_RST, SECOND_SPEC_RST,
            lvl(SECOND_DIR_RST, SECOND_DATA_RST, h2_val, h2_en)});
        net_activity <= 1'b1;
        @(negedge aclk);
        chk("led auto", {31'h0, activity_led_line_n}, 32'h0);
        @(posedge aclk);
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            dir = 8'($random(seed)) & 8'hef;
            // reserved line 4 also keeps its reset data bit
            dat = 8'($random(seed)) | 8'h10;
            h1_val <= 8'($random(seed));
            h1_en <= 8'($random(seed));
            h2_val <= 8'($random(seed));
            wr(OFS_BANK_FIRST, {8'h00, dir, 8'h00, dat});
            rd(OFS_BANK_FIRST);
            chk("first word", rdat,
                {8'h00, dir, 8'h00, lvl(dir, dat, h1_val, h1_en)});
            chk("first oe", {24'h0, first_pin_oe}, {24'h0, dir});
            rd(OFS_BANK_SECOND);
            // keep the other pins' bits, change the spare line direction and two data bits
            wdat = (rdat & ~32'h20202060)
                 | {8'h00, 2'b00, dat[0], 5'h00, 9'h000, dat[2:1], 5'h00};
            sdir = 8'h40 | {2'b00, dat[0], 5'h00};
            wr(OFS_BANK_SECOND, wdat);
            rd(OFS_BANK_SECOND);
            chk("second word", rdat,
                {8'h00, sdir, 8'h00, lvl(sdir, wdat[7:0], h2_val, h2_en)});
            net_activity <= ~net_activity;
            @(negedge aclk);
            chk("led gpio", {31'h0, activity_led_line_n}, {31'h0, wdat[6]});
            @(posedge aclk);
        end
        $display("test pin config done");
        wr(4'h8, 32'hffffffff);
        chk("bad write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        rd(4'hc);
        chk("bad read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        chk("bad read data", rdat, 32'h0);
        rd(OFS_BANK_FIRST);
        chk("first kept", rdat, {8'h00, dir, 8'h00, lvl(dir, dat, h1_val, h1_en)});
        $display("test unmapped done");
        // direction byte alone: the masked function byte and the other fields must stay
        s_axi_wstrb <= 4'h4;
        wr(OFS_BANK_FIRST, 32'hffef_0000);
        s_axi_wstrb <= 4'hf;
        rd(OFS_BANK_FIRST);
        chk("first strobe", rdat, {8'h00, 8'hef, 8'h00, lvl(8'hef, dat, h1_val, h1_en)});
        $display("test strobe done");
        stop_test();
    end
endmodule

// ===== tb/gpio_two_bank_monitor.sv
// port-level checker for the two-bank gpio block
`timescale 1ns/1ns
module gpio_two_bank_monitor
    import gpio_pkg::*;
#(
    parameter int unsigned WIDTH = PINS_PER_BANK
)
(
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [3:0]       s_axi_awaddr,
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic [3:0]       s_axi_araddr,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_rvalid,
    input wire logic [WIDTH-1:0] serial_out,
    input wire logic [WIDTH-1:0] serial_oe,
    input wire logic             net_activity,
    input wire logic [WIDTH-1:0] first_pin_out,
    input wire logic [WIDTH-1:0] first_pin_oe,
    input wire logic [WIDTH-1:0] second_pin_out,
    input wire logic [WIDTH-1:0] second_pin_oe,
    input wire logic             activity_led_line_n
);
    logic       aw_go, first_wr_r, first_wr_nxt, second_wr_r, second_wr_nxt;
    logic       led_own_r, led_own_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt, rd_addr_r, rd_addr_nxt;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////////////
    // a bank counts as touched from address acceptance, so default checks stop early;
    // the led hand-over counts only from the response, when the write has surely landed
    always_comb
    begin
        aw_go         = s_axi_awvalid && s_axi_awready;
        aw_addr_nxt   = aw_go ? s_axi_awaddr : aw_addr_r;
        rd_addr_nxt   = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_r;
        first_wr_nxt  = first_wr_r | (aw_go && s_axi_awaddr == OFS_BANK_FIRST);
        second_wr_nxt = second_wr_r | (aw_go && s_axi_awaddr == OFS_BANK_SECOND);
        led_own_nxt   = led_own_r | (s_axi_bvalid && s_axi_bready
                                     && aw_addr_r == OFS_BANK_SECOND);
    end

    // register the tracking state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            first_wr_r  <= 1'b0;
            second_wr_r <= 1'b0;
            led_own_r   <= 1'b0;
            aw_addr_r   <= 4'h0;
            rd_addr_r   <= 4'h0;
        end
        else
        begin
            first_wr_r  <= first_wr_nxt;
            second_wr_r <= second_wr_nxt;
            led_own_r   <= led_own_nxt;
            aw_addr_r   <= aw_addr_nxt;
            rd_addr_r   <= rd_addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    led_auto_a:
        assert property (!second_wr_r |-> activity_led_line_n == !net_activity)
        else $error("led not following network activity");
    led_default_out_a:
        assert property (!second_wr_r |-> second_pin_oe[ACTIVITY_LED_BIT])
        else $error("led line not an output by default");
    led_gpio_a:
        assert property (led_own_r && second_pin_oe[ACTIVITY_LED_BIT]
            |-> activity_led_line_n == second_pin_out[ACTIVITY_LED_BIT])
        else $error("led does not follow its data bit");
    serial_default_a:
        assert property (!first_wr_r |-> ((first_pin_out ^ serial_out) & FIRST_FUNC_RST) == 8'h00
            && ((first_pin_oe ^ serial_oe) & FIRST_FUNC_RST) == 8'h00)
        else $error("serial lines not routed by default");
    reserved_input_a:
        assert property (!first_wr_r |-> !first_pin_oe[4])
        else $error("reserved first bank line driven");
    spec_zero_a:
        assert property ($rose(s_axi_rvalid) && rd_addr_r == OFS_BANK_FIRST
            |-> s_axi_rdata[15:8] == 8'h00)
        else $error("first bank special field not zero");
    unmapped_read_a:
        assert property ($rose(s_axi_rvalid) && rd_addr_r[3]
            |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

bind gpio_two_bank_config gpio_two_bank_monitor #(.WIDTH(WIDTH)) u_monitor (.*);

// ===== verilog/gpio_pin_bank.sv
// one bank of eight pins: output drive, enables and input sampling
`timescale 1ns/1ns
module gpio_pin_bank
    import gpio_pkg::*;
#(
    parameter int unsigned WIDTH = 8
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire bank_cfg_type     cfg,
    input  wire logic [WIDTH-1:0] alt_out,
    input  wire logic [WIDTH-1:0] alt_oe,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe,
    output logic      [WIDTH-1:0] level_r
);

    logic [WIDTH-1:0] level_nxt;

    // per pin: gpio when func select is clear, peripheral function otherwise
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_pin
            always_comb
            begin
                if (cfg.func_sel[i])
                begin
                    pin_out[i] = alt_out[i];
                    pin_oe[i]  = alt_oe[i];
                end
                else
                begin
                    pin_out[i] = cfg.data[i];              // [R4]
                    pin_oe[i]  = cfg.dir[i] & ~cfg.spec[i]; // [R11]
                end
            end
        end
    endgenerate

    // pin levels are registered once so reads see a stable value
    always_comb
    begin
        level_nxt = pin_in;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_r <= '0;
        else
            level_r <= level_nxt;
    end

endmodule

// ===== verilog/gpio_pkg.sv
// package: register map, field layout and reset values of the two-bank gpio block
package gpio_pkg;

    localparam int unsigned NUM_BANKS      = 2;
    localparam int unsigned PINS_PER_BANK  = 8;

    // byte offsets on the register bus
    localparam logic [3:0]  OFS_BANK_FIRST  = 4'h0;
    localparam logic [3:0]  OFS_BANK_SECOND = 4'h4;

    // field positions inside a bank control word, one bit per pin in each byte
    localparam int unsigned FLD_FUNC_LSB    = 24;
    localparam int unsigned FLD_DIR_LSB     = 16;
    localparam int unsigned FLD_SPEC_LSB    = 8;
    localparam int unsigned FLD_DATA_LSB    = 0;

    // bit positions of named lines
    localparam int unsigned ACTIVITY_LED_BIT = 6;
    localparam int unsigned SPARE_HOST_BIT   = 5;

    // serial lines of the first bank start in special function (func select = 1)
    localparam logic [7:0]  FIRST_FUNC_RST  = 8'hef;
    localparam logic [7:0]  FIRST_DIR_RST   = 8'he0;
    localparam logic [7:0]  FIRST_DATA_RST  = 8'hff;
    // second bank: led line is a gpio output, led off (high)
    localparam logic [7:0]  SECOND_FUNC_RST = 8'h00;
    localparam logic [7:0]  SECOND_DIR_RST  = 8'h40;
    localparam logic [7:0]  SECOND_SPEC_RST = 8'h00;
    localparam logic [7:0]  SECOND_DATA_RST = 8'h40;

    // axi response codes
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // one bank's configuration travels as a packed struct
    typedef struct packed {
        logic [7:0] func_sel;
        logic [7:0] dir;
        logic [7:0] spec;
        logic [7:0] data;
    } bank_cfg_type;

endpackage

// ===== verilog/gpio_two_bank_config.sv
// top of the two-bank gpio block with its axi4-lite register slave
//
// Contract
// [R1] sixteen lines, two eight-pin banks, four bits each
// [R2] software clears all three bits for input
// [R3] software sets direction only for output
// [R4] data reads pin level, write drives outputs
// [R5] software read-modify-writes whole control word
// [R6] software leaves reserved lines untouched
// [R7] led line lit low, kept output
// [R8] led line defaults output, pulses on activity
// [R9] first bank serial lines default to serial
// [R10] spare host line free as gpio
// [R11] input pins ignore data writes externally
`timescale 1ns/1ns
module gpio_two_bank_config
    import gpio_pkg::*;
#(
    parameter int unsigned WIDTH = PINS_PER_BANK
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite slave
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // peripheral side of the first bank (serial port)
    input  wire logic [WIDTH-1:0] serial_out,
    input  wire logic [WIDTH-1:0] serial_oe,
    // activity pulse from the network mac
    input  wire logic             net_activity,
    // header pins
    input  wire logic [WIDTH-1:0] first_pin_in,
    output logic      [WIDTH-1:0] first_pin_out,
    output logic      [WIDTH-1:0] first_pin_oe,
    input  wire logic [WIDTH-1:0] second_pin_in,
    output logic      [WIDTH-1:0] second_pin_out,
    output logic      [WIDTH-1:0] second_pin_oe,
    output logic                  activity_led_line_n
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    bank_cfg_type     first_r,  first_nxt;
    bank_cfg_type     second_r, second_nxt;
    logic             led_auto_r, led_auto_nxt;
    logic [WIDTH-1:0] first_level, second_level;

    // byte-lane merge used by both bank writes
    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[b*8 +: 8] = new_w[b*8 +: 8];
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data may arrive in either order

    logic       aw_held_r, aw_held_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt;
    logic       w_held_r,  w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r,  w_strb_nxt;
    logic       bvalid_r,  bvalid_nxt;
    logic [1:0] bresp_r,   bresp_nxt;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r  && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // capture each half, commit once both are in and no response is pending
    always_comb
    begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        first_nxt   = first_r;
        second_nxt  = second_r;
        led_auto_nxt = led_auto_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (aw_held_r && w_held_r)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = RESP_OKAY;
            unique case (aw_addr_r)
                OFS_BANK_FIRST:
                begin
                    // first bank has no special-function byte, it reads zero
                    first_nxt      = merge_word(first_r, w_data_r, w_strb_r); // [R9]
                    first_nxt.spec = '0;
                end
                OFS_BANK_SECOND:
                begin
                    second_nxt = merge_word(second_r, w_data_r, w_strb_r); // [R10]
                    // any software write to the led bits hands the led to software
                    if (w_strb_r[0] || w_strb_r[3] || w_strb_r[2] || w_strb_r[1])
                        led_auto_nxt = 1'b0; // [R8]
                end
                default:
                    bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r  <= 1'b0;
            aw_addr_r  <= 4'h0;
            w_held_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_strb_r   <= 4'h0;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
            first_r    <= '{FIRST_FUNC_RST, FIRST_DIR_RST, 8'h00, FIRST_DATA_RST}; // [R9]
            second_r   <= '{SECOND_FUNC_RST, SECOND_DIR_RST, SECOND_SPEC_RST,
                            SECOND_DATA_RST}; // [R8]
            led_auto_r <= 1'b1;
        end
        else
        begin
            aw_held_r  <= aw_held_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_held_r   <= w_held_nxt;
            w_data_r   <= w_data_nxt;
            w_strb_r   <= w_strb_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            first_r    <= first_nxt;
            second_r   <= second_nxt;
            led_auto_r <= led_auto_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: one cycle from address to data

    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r,  rdata_nxt;
    logic [1:0]  rresp_r,  rresp_nxt;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // data byte returns sampled pin levels, not the written latch
    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_BANK_FIRST:
                    rdata_nxt = {first_r.func_sel, first_r.dir, 8'h00, first_level}; // [R4]
                OFS_BANK_SECOND:
                    rdata_nxt = {second_r.func_sel, second_r.dir, second_r.spec,
                                 second_level}; // [R4]
                default:
                begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end
        else
        begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led: follows activity until software writes the second bank

    bank_cfg_type second_eff;

    // in auto mode the led data bit is low (lit) while activity is seen
    always_comb
    begin
        second_eff = second_r;
        if (led_auto_r)
            second_eff.data[ACTIVITY_LED_BIT] = ~net_activity; // [R8]
    end

    ////////////////////////////////////////////////////////////////////////
    // pin banks

    gpio_pin_bank #(.WIDTH(WIDTH)) u_first (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (first_r),
        .alt_out (serial_out),
        .alt_oe  (serial_oe),
        .pin_in  (first_pin_in),
        .pin_out (first_pin_out),
        .pin_oe  (first_pin_oe),
        .level_r (first_level)
    ); // [R1]

    gpio_pin_bank #(.WIDTH(WIDTH)) u_second (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cfg     (second_eff),
        .alt_out ('0),
        .alt_oe  ('0),
        .pin_in  (second_pin_in),
        .pin_out (second_pin_out),
        .pin_oe  (second_pin_oe),
        .level_r (second_level)
    ); // [R1]

    // led lit when its line is driven low; dark whenever not driven as output
    assign activity_led_line_n = second_pin_oe[ACTIVITY_LED_BIT]
                               ? second_pin_out[ACTIVITY_LED_BIT] : 1'b1; // [R7]

endmodule
